// *** verilog/ihc_map.svh ***
// Register offsets, field positions, reset values and limits of the interrupt hold block
`ifndef IHC_MAP_SVH
`define IHC_MAP_SVH

`define IHC_NSRC        8
`define IHC_CNT_W       14
`define IHC_PRIO_W      3
`define IHC_STACK_D     8
`define IHC_DEPTH_W     4

`define IHC_OFF_CTRL    12'h000
`define IHC_OFF_HOLD    12'h004
`define IHC_OFF_CORE    12'h008
`define IHC_OFF_SPRIO   12'h00C
`define IHC_OFF_SEN     12'h010
`define IHC_OFF_SFLAG   12'h014
`define IHC_OFF_STAT    12'h018

`define IHC_NEST_DIS_BIT 15

`define IHC_RST_NEST    1'b0
`define IHC_RST_CORE    3'h0
`define IHC_RST_SPRIO   24'h44_4444
`define IHC_RST_SEN     8'h00

`define IHC_BLK_LO      3'h1
`define IHC_BLK_HI      3'h6
`define IHC_LVL_MAX     3'h7

`endif

// *** verilog/ihc_pkg.sv ***
// Types shared by the interrupt hold block
package ihc_pkg;
  `include "ihc_map.svh"
  typedef logic [`IHC_PRIO_W-1:0]  ihc_prio_t;
  typedef logic [`IHC_CNT_W-1:0]   ihc_cnt_t;
  typedef logic [`IHC_NSRC-1:0]    ihc_src_t;
  typedef logic [2:0]              ihc_idx_t;
  typedef logic [`IHC_DEPTH_W-1:0] ihc_depth_t;
endpackage : ihc_pkg

// *** verilog/ihc_hold_if.sv ***
// Load and status signals between the register file and the hold counter
interface ihc_hold_if;
  import ihc_pkg::*;
  logic     instrLoad;
  ihc_cnt_t instrVal;
  logic     swLoad;
  ihc_cnt_t swVal;
  ihc_cnt_t count;
  logic     block;
  modport ctr  (input instrLoad, input instrVal, input swLoad, input swVal, output count, output block);
  modport user (output instrLoad, output instrVal, output swLoad, output swVal, input count, input block);
endinterface : ihc_hold_if

// *** verilog/ihc_hold_counter.sv ***
// Interrupt hold down-counter
module ihc_hold_counter
  import ihc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  ihc_hold_if.ctr  hold
);

  ihc_cnt_t countQ;
  ihc_cnt_t countD;

  always_comb
  begin
    // Instruction load wins over a software write in the same cycle
    if (hold.instrLoad)
      countD = hold.instrVal;
    else if (hold.swLoad)
      countD = hold.swVal;
    else if (countQ != '0)
      countD = countQ - ihc_cnt_t'(1);
    else
      countD = countQ;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      countQ <= '0;
    else
      countQ <= countD;
  end

  // Executing cycle itself counts, then N more; a load at zero re-arms fully
  assign hold.block = hold.instrLoad | (countQ != '0);
  assign hold.count = countQ;

  AST_LOAD_VALUE: assert property (@(posedge clock) disable iff (!nrst)
    hold.instrLoad |=> countQ == $past(hold.instrVal))
    else $error("hold counter not loaded with operand");
  AST_DECREMENT: assert property (@(posedge clock) disable iff (!nrst)
    (countQ != '0 && !hold.instrLoad && !hold.swLoad) |=> countQ == $past(countQ) - ihc_cnt_t'(1))
    else $error("hold counter did not decrement");
  AST_BLOCK_SPAN: assert property (@(posedge clock) disable iff (!nrst)
    (hold.instrLoad && hold.instrVal == ihc_cnt_t'(3) && !hold.swLoad) ##1 (!hold.instrLoad && !hold.swLoad) [*3]
    |-> ##1 !hold.block || hold.instrLoad)
    else $error("hold of 3 did not last exactly 4 cycles");
  AST_INSTR_CYCLE: assert property (@(posedge clock) disable iff (!nrst)
    hold.instrLoad |-> hold.block)
    else $error("hold instruction cycle not blocked");
  AST_RELOAD: assert property (@(posedge clock) disable iff (!nrst)
    (hold.instrLoad && countQ != '0 && hold.instrVal != '0) |=> hold.block && countQ == $past(hold.instrVal))
    else $error("reload before zero lost");
  AST_ZERO_RELOAD: assert property (@(posedge clock) disable iff (!nrst)
    (hold.instrLoad && countQ == '0 && hold.instrVal != '0) |=> hold.block [*1] ##0 countQ != '0)
    else $error("load at zero did not re-engage blocking");
  AST_SW_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    (hold.swLoad && hold.swVal == '0 && !hold.instrLoad) |=> !hold.block || hold.instrLoad)
    else $error("software clear did not end the hold");

endmodule : ihc_hold_counter

// *** verilog/ihc_arbiter.sv ***
// Priority selection and nesting stack of serviced levels
`include "ihc_map.svh"
module ihc_arbiter
  import ihc_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire ihc_src_t                    srcFlag,
  input  wire ihc_src_t                    srcEnable,
  input  wire logic [3*`IHC_NSRC-1:0]      srcPrio,
  input  wire ihc_prio_t                   coreLevel,
  input  wire logic                        nestDisable,
  input  wire logic                        holdBlock,
  input  wire logic                        takeAck,
  input  wire logic                        retDone,
  output logic                             reqValid,
  output ihc_idx_t                         reqIdx,
  output ihc_prio_t                        reqLevel,
  output ihc_prio_t                        curLevel,
  output ihc_depth_t                       depth
);

  ihc_prio_t  stackQ [`IHC_STACK_D];
  ihc_prio_t  stackD [`IHC_STACK_D];
  ihc_depth_t depthQ;
  ihc_depth_t depthD;
  logic       validQ;
  logic       validD;
  ihc_idx_t   idxQ;
  ihc_idx_t   idxD;
  ihc_prio_t  lvlQ;
  ihc_prio_t  lvlD;
  ihc_prio_t  effLevel;
  ihc_prio_t  topLevel;
  ihc_src_t   eligible;
  logic       push;
  logic       pop;

  assign topLevel = (depthQ == '0) ? 3'h0 : stackQ[depthQ[2:0] - 3'h1];
  assign effLevel = (topLevel > coreLevel) ? topLevel : coreLevel;

  always_comb
  begin
    eligible = '0;
    idxD     = idxQ;
    lvlD     = '0;
    validD   = 1'b0;
    for (int i = 0; i < `IHC_NSRC; i++)
    begin
      // Negated if disabled, flag clear or not above the running level
      eligible[i] = srcFlag[i] && srcEnable[i] && (srcPrio[3*i +: 3] > effLevel);
      if (holdBlock && srcPrio[3*i +: 3] >= `IHC_BLK_LO && srcPrio[3*i +: 3] <= `IHC_BLK_HI)
        eligible[i] = 1'b0;
      if (eligible[i] && srcPrio[3*i +: 3] > lvlD)
      begin
        lvlD   = srcPrio[3*i +: 3];
        idxD   = ihc_idx_t'(i);
        validD = 1'b1;
      end
    end
    if (nestDisable && depthQ != '0)
      validD = 1'b0;
    // Stale request must not be taken twice while the stack updates
    if (takeAck && validQ)
      validD = 1'b0;
  end

  assign push = takeAck && validQ;
  assign pop  = retDone && depthQ != '0;

  always_comb
  begin
    stackD = stackQ;
    depthD = depthQ + ihc_depth_t'(push) - ihc_depth_t'(pop);
    // Preemption after software negation is a plain push, no trap path
    if (push)
      stackD[depthD[2:0] - 3'h1] = lvlQ;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `IHC_STACK_D; i++)
        stackQ[i] <= '0;
      depthQ <= '0;
      validQ <= 1'b0;
      idxQ   <= '0;
      lvlQ   <= '0;
    end
    else
    begin
      stackQ <= stackD;
      depthQ <= depthD;
      validQ <= validD;
      idxQ   <= idxD;
      lvlQ   <= lvlD;
    end
  end

  assign reqValid = validQ;
  assign reqIdx   = idxQ;
  assign reqLevel = lvlQ;
  assign curLevel = topLevel;
  assign depth    = depthQ;

  AST_HOLD_MASK: assert property (@(posedge clock) disable iff (!nrst)
    ($past(holdBlock) && validQ) |-> lvlQ == `IHC_LVL_MAX || lvlQ == 3'h0)
    else $error("level 1 to 6 request passed during hold");
  AST_NEGATED: assert property (@(posedge clock) disable iff (!nrst)
    validQ |-> $past(srcFlag[idxD]) && $past(srcEnable[idxD]) && lvlQ > $past(effLevel))
    else $error("negated source requested");
  AST_NEST_OFF: assert property (@(posedge clock) disable iff (!nrst)
    $past(nestDisable && depthQ != '0) |-> !validQ)
    else $error("nesting while disabled");
  AST_PREEMPT: assert property (@(posedge clock) disable iff (!nrst)
    (!nestDisable && depthQ != '0 && !holdBlock && !push && (eligible != '0)) |=> validQ)
    else $error("higher request did not preempt");
  AST_SERVICE: assert property (@(posedge clock) disable iff (!nrst)
    (push && !pop && depthQ < ihc_depth_t'(`IHC_STACK_D)) |=> curLevel == $past(lvlQ) && depthQ == $past(depthQ) + 1'b1)
    else $error("taken request not serviced at its level");

endmodule : ihc_arbiter

// *** verilog/ihc_top.sv ***
// Interrupt hold counter and nesting control with APB register access
`include "ihc_map.svh"
module ihc_top
  import ihc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        holdExec,
  input  wire ihc_cnt_t    holdOperand,
  input  wire ihc_src_t    srcEvent,
  input  wire logic        takeAck,
  input  wire logic        retDone,
  output logic             irqReq,
  output ihc_idx_t         irqIdx,
  output ihc_prio_t        irqLevel,
  output logic             holdActive,
  output ihc_prio_t        serviceLevel
);

  ihc_hold_if hold ();

  logic             nestDisQ;
  logic             nestDisD;
  ihc_prio_t        coreLvlQ;
  ihc_prio_t        coreLvlD;
  logic [23:0]      srcPrioQ;
  logic [23:0]      srcPrioD;
  ihc_src_t         srcEnQ;
  ihc_src_t         srcEnD;
  ihc_src_t         srcFlagQ;
  ihc_src_t         srcFlagD;
  logic [31:0]      rdataQ;
  logic [31:0]      rdataD;
  logic             errQ;
  logic             errD;
  logic             setup;
  logic             wrAcc;
  logic             mapped;
  logic [31:0]      rdMux;
  logic [31:0]      wmask;
  ihc_depth_t       depth;
  logic             reqValid;

  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite && !errQ;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_comb
  begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    unique case (paddr)
      `IHC_OFF_CTRL:  rdMux[`IHC_NEST_DIS_BIT] = nestDisQ;
      `IHC_OFF_HOLD:  rdMux[`IHC_CNT_W-1:0] = hold.count;
      `IHC_OFF_CORE:  rdMux[2:0] = coreLvlQ;
      `IHC_OFF_SPRIO: rdMux[23:0] = srcPrioQ;
      `IHC_OFF_SEN:   rdMux[7:0] = srcEnQ;
      `IHC_OFF_SFLAG: rdMux[7:0] = srcFlagQ;
      `IHC_OFF_STAT:  rdMux[15:0] = {depth, serviceLevel, 1'b0, irqLevel, reqValid, irqIdx, holdActive};
      default:        mapped = 1'b0;
    endcase
  end

  // Register file next values
  always_comb
  begin
    nestDisD = nestDisQ;
    coreLvlD = coreLvlQ;
    srcPrioD = srcPrioQ;
    srcEnD   = srcEnQ;
    srcFlagD = srcFlagQ;
    rdataD   = rdataQ;
    errD     = errQ;
    if (setup)
    begin
      // Answer captured at setup so read data comes from a flop
      rdataD = pwrite ? 32'h0000_0000 : rdMux;
      errD   = !mapped;
    end
    if (wrAcc)
    begin
      unique case (paddr)
        `IHC_OFF_CTRL:
        begin
          if (pstrb[1])
            nestDisD = pwdata[`IHC_NEST_DIS_BIT];
        end
        `IHC_OFF_CORE:
        begin
          if (pstrb[0])
            coreLvlD = pwdata[2:0];
        end
        `IHC_OFF_SPRIO: srcPrioD = 24'(merge({8'h00, srcPrioQ}, pwdata, wmask));
        `IHC_OFF_SEN:
        begin
          if (pstrb[0])
            srcEnD = pwdata[7:0];
        end
        `IHC_OFF_SFLAG:
        begin
          if (pstrb[0])
            srcFlagD = srcFlagQ & ~pwdata[7:0];
        end
        default: ;
      endcase
    end
    // Event beats a same-cycle clear
    srcFlagD = srcFlagD | srcEvent;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      nestDisQ <= `IHC_RST_NEST;
      coreLvlQ <= `IHC_RST_CORE;
      srcPrioQ <= `IHC_RST_SPRIO;
      srcEnQ   <= `IHC_RST_SEN;
      srcFlagQ <= '0;
      rdataQ   <= 32'h0000_0000;
      errQ     <= 1'b0;
    end
    else
    begin
      nestDisQ <= nestDisD;
      coreLvlQ <= coreLvlD;
      srcPrioQ <= srcPrioD;
      srcEnQ   <= srcEnD;
      srcFlagQ <= srcFlagD;
      rdataQ   <= rdataD;
      errQ     <= errD;
    end
  end

  assign prdata  = rdataQ;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && errQ;

  // Low-pin writes of the counter word only touch the count field
  assign hold.instrLoad = holdExec;
  assign hold.instrVal  = holdOperand;
  assign hold.swLoad    = wrAcc && paddr == `IHC_OFF_HOLD && (pstrb[0] || pstrb[1]);
  assign hold.swVal     = ihc_cnt_t'(merge({18'h0_0000, hold.count}, pwdata, wmask));

  ihc_hold_counter u_counter (
    .clock (clock),
    .nrst  (nrst),
    .hold  (hold.ctr)
  );

  ihc_arbiter u_arbiter (
    .clock       (clock),
    .nrst        (nrst),
    .srcFlag     (srcFlagQ),
    .srcEnable   (srcEnQ),
    .srcPrio     (srcPrioQ),
    .coreLevel   (coreLvlQ),
    .nestDisable (nestDisQ),
    .holdBlock   (hold.block),
    .takeAck     (takeAck),
    .retDone     (retDone),
    .reqValid    (reqValid),
    .reqIdx      (irqIdx),
    .reqLevel    (irqLevel),
    .curLevel    (serviceLevel),
    .depth       (depth)
  );

  assign irqReq     = reqValid;
  assign holdActive = hold.block;

  AST_FLAG_SET_WINS: assert property (@(posedge clock) disable iff (!nrst)
    (srcEvent != '0) |=> (srcFlagQ & $past(srcEvent)) == $past(srcEvent))
    else $error("event lost against flag clear");
  AST_NEST_BIT: assert property (@(posedge clock) disable iff (!nrst)
    (wrAcc && paddr == `IHC_OFF_CTRL && pstrb[1]) |=> nestDisQ == $past(pwdata[`IHC_NEST_DIS_BIT]))
    else $error("nesting-disable bit not written");
  AST_APB_ERR: assert property (@(posedge clock) disable iff (!nrst)
    (setup && !mapped) |=> pslverr || !(psel && penable))
    else $error("unmapped address not flagged");

endmodule : ihc_top

// *** tb/ihc_core_model.sv ***
// Core-side model: takes offered requests and signals returns
module ihc_core_model
  import ihc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       irqReq,
  input  wire logic       ackEn,
  input  wire logic [3:0] ackWait,
  input  wire logic       retReq,
  output logic            takeAck,
  output logic            retDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt_q;
  logic [3:0] waitCnt_d;
  logic       ret_q;
  logic       ret_d;

  // Ack only while offered, so an ack never lands on a withdrawn request
  assign takeAck = ackEn & irqReq & (waitCnt_q >= ackWait);
  assign retDone = ret_q;

  always_comb
  begin
    waitCnt_d = (irqReq && !takeAck && waitCnt_q != 4'hF) ? waitCnt_q + 4'h1 : 4'h0;
    ret_d     = retReq;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      waitCnt_q <= 4'h0;
      ret_q     <= 1'b0;
    end
    else
    begin
      waitCnt_q <= waitCnt_d;
      ret_q     <= ret_d;
    end
  end
endmodule : ihc_core_model

// *** tb/ihc_top_tb.sv ***
// Self-checking bench for the interrupt hold and nesting block
`include "ihc_map.svh"
module ihc_top_tb
  import ihc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        nrst, psel, penable, pwrite, holdExec, takeAck, retDone, retReq, ackEn;
  logic        pready, pslverr, irqReq, holdActive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ackWait;
  ihc_cnt_t    holdOperand;
  ihc_src_t    srcEvent;
  ihc_idx_t    irqIdx;
  ihc_prio_t   irqLevel, serviceLevel;
  int          errorCnt, testsRun;

  always #20 clock = ~clock;

  ihc_top ihc_top_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .holdExec(holdExec), .holdOperand(holdOperand), .srcEvent(srcEvent), .takeAck(takeAck),
    .retDone(retDone), .irqReq(irqReq), .irqIdx(irqIdx), .irqLevel(irqLevel),
    .holdActive(holdActive), .serviceLevel(serviceLevel));

  ihc_core_model ihc_core_model_inst (.clock(clock), .nrst(nrst), .irqReq(irqReq), .ackEn(ackEn),
    .ackWait(ackWait), .retReq(retReq), .takeAck(takeAck), .retDone(retDone));

  task automatic complete_run;
    if (errorCnt == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge clock);
    holdExec <= 1'b0;
    srcEvent <= 8'h00;
    retReq   <= 1'b0;
  endtask : tick

  // Answer sampled settled before the edge that ends the access; only the watchdog bounds the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic eErr);
    tick();
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    tick();
    penable <= 1'b1;
    @(negedge clock);
    while (pready !== 1'b1)
      @(negedge clock);
    if (!wr)
      chk(prdata, d);
    chk(32'(pslverr), 32'(eErr));
    tick();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic hold(input ihc_cnt_t n);
    @(posedge clock);
    holdExec    <= 1'b1;
    holdOperand <= n;
  endtask : hold

  task automatic ev(input ihc_src_t m);
    @(posedge clock);
    srcEvent <= m;
    settle();
  endtask : ev

  task automatic ret;
    @(posedge clock);
    retReq <= 1'b1;
  endtask : ret

  task automatic settle;
    repeat (8) tick();
    @(negedge clock);
  endtask : settle

  task automatic expectHold(input int hi);
    for (int i = 0; i <= hi; i++)
    begin
      @(negedge clock);
      chk(32'(holdActive), 32'(i < hi));
      tick();
    end
  endtask : expectHold

  initial
  begin
    #800000;
    errorCnt++;
    complete_run();
  end

  initial
  begin
    {nrst, psel, penable, pwrite, holdExec, retReq, ackEn} = 7'h00;
    {paddr, pwdata, holdOperand, srcEvent, ackWait} = '0;
    errorCnt = 0;
    testsRun = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, `IHC_OFF_CTRL, 32'h0000_0000, 1'b0);
    apb(1'b0, `IHC_OFF_SPRIO, {8'h00, `IHC_RST_SPRIO}, 1'b0);
    apb(1'b0, `IHC_OFF_SEN, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h01C, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h01C, 32'h0000_0055, 1'b1);
    hold(14'h0003);
    expectHold(4);
    hold(14'h0005);
    hold(14'h0002);
    expectHold(3);
    hold(14'h0001);
    tick();
    hold(14'h0003);
    expectHold(4);
    hold(14'h1FFF);
    apb(1'b1, `IHC_OFF_HOLD, 32'h0000_0000, 1'b0);
    @(negedge clock);
    chk(32'(holdActive), 32'h0000_0000);
    apb(1'b0, `IHC_OFF_HOLD, 32'h0000_0000, 1'b0);
    apb(1'b1, `IHC_OFF_HOLD, 32'h0000_000A, 1'b0);
    expectHold(10);
    // Source 2 at level 3, source 3 at 5, source 5 at 7
    apb(1'b1, `IHC_OFF_SPRIO, 32'h0003_8AC0, 1'b0);
    ev(8'h04);
    chk(32'(irqReq), 32'h0000_0000);
    apb(1'b1, `IHC_OFF_SEN, 32'h0000_00FF, 1'b0);
    settle();
    chk(32'({irqReq, irqIdx, irqLevel}), 32'h0000_0053);
    apb(1'b1, `IHC_OFF_CORE, 32'h0000_0003, 1'b0);
    settle();
    chk(32'(irqReq), 32'h0000_0000);
    apb(1'b1, `IHC_OFF_CORE, 32'h0000_0000, 1'b0);
    hold(14'h0028);
    settle();
    chk(32'(irqReq), 32'h0000_0000);
    ev(8'h20);
    chk(32'({irqReq, irqIdx, irqLevel}), 32'h0000_006F);
    apb(1'b1, `IHC_OFF_SFLAG, 32'h0000_0020, 1'b0);
    settle();
    chk(32'(irqReq), 32'h0000_0000);
    apb(1'b1, `IHC_OFF_HOLD, 32'h0000_0000, 1'b0);
    settle();
    chk(32'({irqReq, irqIdx, irqLevel}), 32'h0000_0053);
    apb(1'b0, `IHC_OFF_STAT, 32'h0000_0074, 1'b0);
    tick();
    ackEn <= 1'b1;
    settle();
    chk(32'(serviceLevel), 32'h0000_0003);
    hold(14'h0002);
    apb(1'b1, `IHC_OFF_SFLAG, 32'h0000_0004, 1'b0);
    ev(8'h08);
    chk(32'(serviceLevel), 32'h0000_0005);
    apb(1'b1, `IHC_OFF_SFLAG, 32'h0000_0008, 1'b0);
    ret();
    ret();
    settle();
    chk(32'(serviceLevel), 32'h0000_0000);
    apb(1'b1, `IHC_OFF_CTRL, 32'h0000_8000, 1'b0);
    apb(1'b0, `IHC_OFF_CTRL, 32'h0000_8000, 1'b0);
    ackWait <= 4'h2;
    ev(8'h04);
    chk(32'(serviceLevel), 32'h0000_0003);
    ev(8'h08);
    chk(32'({irqReq, serviceLevel}), 32'h0000_0003);
    apb(1'b1, `IHC_OFF_CTRL, 32'h0000_0000, 1'b0);
    settle();
    chk(32'(serviceLevel), 32'h0000_0005);
    apb(1'b0, `IHC_OFF_STAT, 32'h0000_2A06, 1'b0);
    complete_run();
  end
endmodule : ihc_top_tb
